// File: adczd_consts.vh
// adczd_consts.vh: offsets, field positions, reset values and timing counts
// for the control port and zero-detect block. definitions only.
`ifndef ADCZD_CONSTS_VH
`define ADCZD_CONSTS_VH

// ---------------------------------------------------------------
// register indices (seven-bit index field of the control word)
// ---------------------------------------------------------------
`define ADCZD_IDX_ATT_L      7'h10
`define ADCZD_IDX_ATT_R      7'h11
`define ADCZD_IDX_FMT_CTL    7'h12
`define ADCZD_IDX_FILT_CTL   7'h13
`define ADCZD_IDX_MODE_CTL   7'h14
`define ADCZD_IDX_ZERO_CTL   7'h15
`define ADCZD_IDX_ZERO_STAT  7'h16

// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define ADCZD_WORD_BITS      16
`define ADCZD_RW_BIT         15
`define ADCZD_IDX_MSB        14
`define ADCZD_IDX_LSB        8
`define ADCZD_DATA_MSB       7

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ADCZD_FMT_MUTE       0
`define ADCZD_FMT_DME        1
`define ADCZD_FMT_DMF_LSB    2
`define ADCZD_FMT_FMT_LSB    4
`define ADCZD_FILT_RDBK_EN   3
`define ADCZD_MODE_STREAM    5
`define ADCZD_MODE_DFBYP     4
`define ADCZD_ZCTL_CRIT0     1
`define ADCZD_ZCTL_CRIT1     2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ADCZD_RST_ATT        8'hff
`define ADCZD_RST_FMT_CTL    8'h50
`define ADCZD_RST_FILT_CTL   8'h00
`define ADCZD_RST_MODE_CTL   8'h00
`define ADCZD_RST_ZERO_CTL   8'h01

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ADCZD_CLK_HZ         125000000
`define ADCZD_ZERO_WORDS     1024
`define ADCZD_STREAM_ZERO_MS 23
`define ADCZD_STREAM_ZERO_CYC ((`ADCZD_CLK_HZ / 1000) * `ADCZD_STREAM_ZERO_MS)
`define ADCZD_STREAM_PATTERN 8'h96

`endif

// File: adczd_host.sv
// adczd_host.sv: host controller model for the control port.
// assumes clk_i is the system clock; each bit clock phase lasts ten
// cycles so readback bits settle well before they are sampled.
`timescale 1ns/1ps

module adczd_host
(
  // clock
  input  wire clk_i,
  // control port
  input  wire rdbk_i,
  output reg  control_serial_in_o,
  output reg  control_bit_clock_o,
  output reg  control_select_n_o
);
  initial
  begin
    control_serial_in_o = 1'b0;
    control_bit_clock_o = 1'b0;
    control_select_n_o  = 1'b1;
  end

  task automatic wait_c(input integer n);
  begin
    repeat (n) @(posedge clk_i);
    #1;
  end
  endtask

  // n below 16 aborts the word on purpose
  task automatic xfer(input [15:0] w, input integer n, output [7:0] rd);
    integer i;
  begin
    rd = 8'h00;
    wait_c(2);
    control_select_n_o = 1'b0;
    for (i = 15; i > 15 - n; i = i - 1)
    begin
      control_serial_in_o = w[i];
      wait_c(10);
      if (i < 8)
        rd[i] = rdbk_i;
      control_bit_clock_o = 1'b1;
      wait_c(10);
      control_bit_clock_o = 1'b0;
    end
    // released data line shows the inverse, not a held value
    control_serial_in_o = ~control_serial_in_o;
    wait_c(10);
    control_select_n_o = 1'b1;
    wait_c(10);
  end
  endtask
endmodule // adczd_host

// File: adczd_sync.v
// adczd_sync.v: three-flop synchroniser with agreement filter.
// assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps

module adczd_sync
#(
  parameter W = 1
)
(
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // data
  input  wire [W-1:0] async_i,
  input  wire [W-1:0] rst_val_i,
  output reg  [W-1:0] sync_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      // first stage read only by the second
      always @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          meta_ff[g] <= 1'b0;
          s2_ff[g]   <= 1'b0;
          s3_ff[g]   <= 1'b0;
          sync_o[g]  <= 1'b0;
        end
        else
        begin
          meta_ff[g] <= async_i[g];
          s2_ff[g]   <= meta_ff[g];
          s3_ff[g]   <= s2_ff[g];
          // change counts only when stages two and three agree
          if (s2_ff[g] == s3_ff[g])
            sync_o[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

endmodule // adczd_sync

// File: adczd_top.v
// adczd_top.v: control port, mode registers and zero detection.
// assumes all pins arrive asynchronously to SYS_CLK_I and that the
// control bit clock is much slower than SYS_CLK_I (>= 100 ns period).
`timescale 1ns/1ps
`include "adczd_consts.vh"

module adczd_top
#(
  parameter ZERO_WORDS  = `ADCZD_ZERO_WORDS,
  parameter STREAM_CYC  = `ADCZD_STREAM_ZERO_CYC,
  parameter RAMP_DIV    = 255
)
(
  // system
  input  wire       SYS_CLK_I,
  input  wire       RST_N_I,
  // control port
  input  wire       CONTROL_SERIAL_IN_I,
  input  wire       CONTROL_BIT_CLOCK_I,
  input  wire       CONTROL_SELECT_N_I,
  // pcm / filter port
  input  wire       PCM_WORD_CLOCK_I,
  input  wire       PCM_BIT_CLOCK_I,
  input  wire       PCM_DATA_I,
  // one-bit stream port
  input  wire       STREAM_BIT_CLOCK_I,
  input  wire       STREAM_LEFT_DATA_I,
  input  wire       STREAM_RIGHT_DATA_I,
  // zero flag pins
  output reg        LEFT_ZERO_FLAG_PIN_O,
  output reg        RIGHT_ZERO_FLAG_PIN_O,
  // settings toward the datapath
  output reg  [7:0] LEFT_GAIN_O,
  output reg  [7:0] RIGHT_GAIN_O,
  output reg  [2:0] INPUT_FORMAT_O,
  output reg  [1:0] EMPHASIS_RATE_O,
  output reg        EMPHASIS_ENABLE_O,
  output reg        OUTPUT_PHASE_INVERT_O,
  output reg        ONE_BIT_STREAM_MODE_O,
  output reg        STREAM_LEFT_BIT_O,
  output reg        STREAM_RIGHT_BIT_O,
  output reg        STREAM_BIT_VALID_O
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire [8:0] pin_sync;
  adczd_sync #(.W(9)) u_sync
  (
    .clk_i     (SYS_CLK_I),
    .rst_n_i   (RST_N_I),
    .async_i   ({CONTROL_SERIAL_IN_I, CONTROL_BIT_CLOCK_I,
                 CONTROL_SELECT_N_I, PCM_WORD_CLOCK_I, PCM_BIT_CLOCK_I,
                 PCM_DATA_I, STREAM_BIT_CLOCK_I, STREAM_LEFT_DATA_I,
                 STREAM_RIGHT_DATA_I}),
    .rst_val_i (9'h000),
    .sync_o    (pin_sync)
  );

  wire mdi_s  = pin_sync[8];
  wire mc_s   = pin_sync[7];
  wire sel_n_s = pin_sync[6];
  wire wck_s  = pin_sync[5];
  wire bck_s  = pin_sync[4];
  wire pd_s   = pin_sync[3];
  wire sbck_s = pin_sync[2];
  wire sdl_s  = pin_sync[1];
  wire sdr_s  = pin_sync[0];

  reg mc_d_ff;
  reg wck_d_ff;
  reg bck_d_ff;
  reg sbck_d_ff;
  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mc_d_ff   <= 1'b0;
      wck_d_ff  <= 1'b0;
      bck_d_ff  <= 1'b0;
      sbck_d_ff <= 1'b0;
    end
    else
    begin
      mc_d_ff   <= mc_s;
      wck_d_ff  <= wck_s;
      bck_d_ff  <= bck_s;
      sbck_d_ff <= sbck_s;
    end
  end

  wire mc_rise  = mc_s & ~mc_d_ff;
  wire mc_fall  = ~mc_s & mc_d_ff;
  wire wck_edge = wck_s ^ wck_d_ff;
  wire bck_rise = bck_s & ~bck_d_ff;
  wire sbck_rise = sbck_s & ~sbck_d_ff;

  // ---------------------------------------------------------------
  // mode registers
  // ---------------------------------------------------------------
  reg [7:0] att_l_ff;
  reg [7:0] att_r_ff;
  reg [7:0] fmt_ctl_ff;
  reg [7:0] filt_ctl_ff;
  reg [7:0] mode_ctl_ff;
  reg [7:0] zero_ctl_ff;
  reg       zero_l_ff;
  reg       zero_r_ff;

  wire stream_mode = mode_ctl_ff[`ADCZD_MODE_STREAM];
  wire df_bypass   = mode_ctl_ff[`ADCZD_MODE_DFBYP];
  wire rdbk_en     = filt_ctl_ff[`ADCZD_FILT_RDBK_EN];
  wire soft_mute   = fmt_ctl_ff[`ADCZD_FMT_MUTE];

  // ---------------------------------------------------------------
  // control port: shifts on its own clock and select only
  // ---------------------------------------------------------------
  reg [15:0] shift_ff;
  reg [4:0]  bit_cnt_ff;
  reg [7:0]  rd_sh_ff;
  reg        rd_act_ff;
  reg        done_ff;

  reg [7:0] rd_val;
  always @*
  begin
    case ({shift_ff[5:0], mdi_s})
      `ADCZD_IDX_ATT_L:     rd_val = att_l_ff;
      `ADCZD_IDX_ATT_R:     rd_val = att_r_ff;
      `ADCZD_IDX_FMT_CTL:   rd_val = fmt_ctl_ff;
      `ADCZD_IDX_FILT_CTL:  rd_val = filt_ctl_ff;
      `ADCZD_IDX_MODE_CTL:  rd_val = mode_ctl_ff;
      `ADCZD_IDX_ZERO_CTL:  rd_val = zero_ctl_ff;
      `ADCZD_IDX_ZERO_STAT: rd_val = {6'h00, zero_r_ff, zero_l_ff};
      default:              rd_val = 8'h00;
    endcase
  end

  wire [6:0] wr_idx = shift_ff[`ADCZD_IDX_MSB-1:`ADCZD_IDX_LSB-1];
  wire       wr_dir = shift_ff[`ADCZD_RW_BIT-1];
  wire [7:0] wr_dat = {shift_ff[`ADCZD_DATA_MSB-1:0], mdi_s};
  wire       word_end = mc_rise & ~sel_n_s & ~done_ff &
                        (bit_cnt_ff == 5'h0f);

  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      shift_ff   <= 16'h0000;
      bit_cnt_ff <= 5'h00;
      rd_sh_ff   <= 8'h00;
      rd_act_ff  <= 1'b0;
      done_ff    <= 1'b0;
    end
    else if (sel_n_s)
    begin
      // select high ends any word and re-arms the port
      bit_cnt_ff <= 5'h00;
      rd_act_ff  <= 1'b0;
      done_ff    <= 1'b0;
    end
    else
    begin
      if (mc_rise && !done_ff)
      begin
        shift_ff   <= {shift_ff[14:0], mdi_s};
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff == 5'h0f)
          done_ff <= 1'b1;
        // index complete after eighth clock: load read data
        if (bit_cnt_ff == 5'h07)
        begin
          rd_act_ff <= shift_ff[6];
          rd_sh_ff  <= rd_val;
        end
      end
      // next read bit appears after each later falling clock
      if (mc_fall && rd_act_ff && bit_cnt_ff > 5'h08)
        rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
    end
  end

  // read index: six bits already shifted plus the eighth bit on the line,
  // so the lookup is ready in the same cycle as the eighth clock

  // ---------------------------------------------------------------
  // register writes, only after the sixteenth clock
  // ---------------------------------------------------------------
  wire do_wr = word_end & ~wr_dir;

  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      att_l_ff    <= `ADCZD_RST_ATT;
      att_r_ff    <= `ADCZD_RST_ATT;
      fmt_ctl_ff  <= `ADCZD_RST_FMT_CTL;
      filt_ctl_ff <= `ADCZD_RST_FILT_CTL;
      mode_ctl_ff <= `ADCZD_RST_MODE_CTL;
      zero_ctl_ff <= `ADCZD_RST_ZERO_CTL;
    end
    else if (do_wr)
    begin
      case (wr_idx)
        `ADCZD_IDX_ATT_L:    att_l_ff    <= wr_dat;
        `ADCZD_IDX_ATT_R:    att_r_ff    <= wr_dat;
        `ADCZD_IDX_FMT_CTL:  fmt_ctl_ff  <= wr_dat;
        `ADCZD_IDX_FILT_CTL: filt_ctl_ff <= wr_dat;
        `ADCZD_IDX_MODE_CTL: mode_ctl_ff <= wr_dat;
        `ADCZD_IDX_ZERO_CTL: zero_ctl_ff <= wr_dat;
        default:             mode_ctl_ff <= mode_ctl_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pcm / filter zero detect, one counter per channel
  // ---------------------------------------------------------------
  // pcm data is low for a word period when no bit sampled high
  reg        seen_l_ff;
  reg        seen_r_ff;
  reg [10:0] pz_l_ff;
  reg [10:0] pz_r_ff;
  // filter mode carries mono data; both channels share the pcm line
  wire left_half = df_bypass ? 1'b1 : ~wck_s;
  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      seen_l_ff <= 1'b0;
      seen_r_ff <= 1'b0;
      pz_l_ff   <= 11'h000;
      pz_r_ff   <= 11'h000;
    end
    else
    begin
      // count on the closing edge of each word period
      if (wck_edge && !wck_s)
      begin
        seen_l_ff <= 1'b0;
        seen_r_ff <= 1'b0;
        pz_l_ff <= seen_l_ff ? 11'h000 :
                   (pz_l_ff == ZERO_WORDS[10:0]) ? pz_l_ff :
                   pz_l_ff + 11'h001;
        pz_r_ff <= seen_r_ff ? 11'h000 :
                   (pz_r_ff == ZERO_WORDS[10:0]) ? pz_r_ff :
                   pz_r_ff + 11'h001;
      end
      // set after clear: a high bit on the closing edge is never lost
      if (bck_rise && pd_s)
      begin
        if (left_half || df_bypass)
          seen_l_ff <= 1'b1;
        if (!left_half || df_bypass)
          seen_r_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // stream zero detect: 8-bit groups, per channel
  // ---------------------------------------------------------------
  reg [7:0]  grp_l_ff;
  reg [7:0]  grp_r_ff;
  reg [2:0]  grp_cnt_ff;
  reg        ok_l_ff;
  reg        ok_r_ff;
  reg [31:0] sz_l_ff;
  reg [31:0] sz_r_ff;

  function grp_ok;
    input [7:0] g;
    input       crit_pat;
    reg   [3:0] ones;
    integer     k;
    begin
      ones = 4'h0;
      for (k = 0; k < 8; k = k + 1)
        ones = ones + {3'h0, g[k]};
      grp_ok = crit_pat ? (g == `ADCZD_STREAM_PATTERN)
                        : (ones == 4'h4);
    end
  endfunction

  wire crit_pat = zero_ctl_ff[`ADCZD_ZCTL_CRIT1];
  wire crit_on  = zero_ctl_ff[`ADCZD_ZCTL_CRIT0] | crit_pat;
  wire [7:0] nxt_grp_l = {grp_l_ff[6:0], sdl_s};
  wire [7:0] nxt_grp_r = {grp_r_ff[6:0], sdr_s};

  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      grp_l_ff   <= 8'h00;
      grp_r_ff   <= 8'h00;
      grp_cnt_ff <= 3'h0;
      ok_l_ff    <= 1'b0;
      ok_r_ff    <= 1'b0;
    end
    else if (sbck_rise && stream_mode)
    begin
      grp_l_ff   <= nxt_grp_l;
      grp_r_ff   <= nxt_grp_r;
      grp_cnt_ff <= grp_cnt_ff + 3'h1;
      if (grp_cnt_ff == 3'h7)
      begin
        ok_l_ff <= crit_on & grp_ok(nxt_grp_l, crit_pat);
        ok_r_ff <= crit_on & grp_ok(nxt_grp_r, crit_pat);
      end
    end
  end

  // time the run of good groups on the system clock
  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sz_l_ff <= 32'h0;
      sz_r_ff <= 32'h0;
    end
    else
    begin
      sz_l_ff <= (!ok_l_ff || !stream_mode) ? 32'h0 :
                 (sz_l_ff == STREAM_CYC) ? sz_l_ff : sz_l_ff + 32'h1;
      sz_r_ff <= (!ok_r_ff || !stream_mode) ? 32'h0 :
                 (sz_r_ff == STREAM_CYC) ? sz_r_ff : sz_r_ff + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // zero flags, pins and datapath outputs
  // ---------------------------------------------------------------
  wire zl = stream_mode ? (sz_l_ff == STREAM_CYC)
                        : (pz_l_ff == ZERO_WORDS[10:0]);
  wire zr = stream_mode ? (sz_r_ff == STREAM_CYC)
                        : (pz_r_ff == ZERO_WORDS[10:0]);

  // soft mute ramps the gain down one half-db step per RAMP_DIV + 1 cycles
  reg [7:0] ramp_cnt_ff;
  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      zero_l_ff             <= 1'b0;
      zero_r_ff             <= 1'b0;
      LEFT_ZERO_FLAG_PIN_O  <= 1'b0;
      RIGHT_ZERO_FLAG_PIN_O <= 1'b0;
      LEFT_GAIN_O           <= `ADCZD_RST_ATT;
      RIGHT_GAIN_O          <= `ADCZD_RST_ATT;
      ramp_cnt_ff           <= 8'h00;
      INPUT_FORMAT_O        <= 3'h5;
      EMPHASIS_RATE_O       <= 2'h0;
      EMPHASIS_ENABLE_O     <= 1'b0;
      OUTPUT_PHASE_INVERT_O <= 1'b0;
      ONE_BIT_STREAM_MODE_O <= 1'b0;
      STREAM_LEFT_BIT_O     <= 1'b0;
      STREAM_RIGHT_BIT_O    <= 1'b0;
      STREAM_BIT_VALID_O    <= 1'b0;
    end
    else
    begin
      zero_l_ff <= zl;
      zero_r_ff <= zr;
      if (rdbk_en)
      begin
        LEFT_ZERO_FLAG_PIN_O  <= rd_act_ff & rd_sh_ff[7];
        RIGHT_ZERO_FLAG_PIN_O <= zl & zr;
      end
      else
      begin
        LEFT_ZERO_FLAG_PIN_O  <= zl;
        RIGHT_ZERO_FLAG_PIN_O <= zr;
      end
      ramp_cnt_ff <= (ramp_cnt_ff == RAMP_DIV[7:0]) ? 8'h00
                                                    : ramp_cnt_ff + 8'h01;
      if (stream_mode)
      begin
        LEFT_GAIN_O  <= `ADCZD_RST_ATT;
        RIGHT_GAIN_O <= `ADCZD_RST_ATT;
      end
      else if (soft_mute)
      begin
        if (ramp_cnt_ff == 8'h00 && LEFT_GAIN_O != 8'h00)
          LEFT_GAIN_O <= LEFT_GAIN_O - 8'h01;
        if (ramp_cnt_ff == 8'h00 && RIGHT_GAIN_O != 8'h00)
          RIGHT_GAIN_O <= RIGHT_GAIN_O - 8'h01;
      end
      else
      begin
        LEFT_GAIN_O  <= att_l_ff;
        RIGHT_GAIN_O <= att_r_ff;
      end
      INPUT_FORMAT_O        <= fmt_ctl_ff[`ADCZD_FMT_FMT_LSB+2:
                                          `ADCZD_FMT_FMT_LSB];
      EMPHASIS_RATE_O       <= fmt_ctl_ff[`ADCZD_FMT_DMF_LSB+1:
                                          `ADCZD_FMT_DMF_LSB];
      EMPHASIS_ENABLE_O     <= fmt_ctl_ff[`ADCZD_FMT_DME];
      OUTPUT_PHASE_INVERT_O <= filt_ctl_ff[7];
      ONE_BIT_STREAM_MODE_O <= stream_mode;
      STREAM_BIT_VALID_O    <= sbck_rise & stream_mode;
      if (sbck_rise && stream_mode)
      begin
        STREAM_LEFT_BIT_O  <= sdl_s;
        STREAM_RIGHT_BIT_O <= sdr_s;
      end
    end
  end

endmodule // adczd_top

// File: adczd_top_sva.sv
// adczd_top_sva.sv: port-level checker for adczd_top, bound at the foot.
// assumes select idles high between words and gains move only by writes
// or by the soft mute ramp.
`timescale 1ns/1ps

module adczd_chk
#(
  parameter ZERO_WORDS = 4,
  parameter STREAM_CYC = 200
)
(
  // system
  input wire       SYS_CLK_I,
  input wire       RST_N_I,
  // watched inputs
  input wire       CONTROL_SELECT_N_I,
  input wire       PCM_DATA_I,
  input wire       STREAM_BIT_CLOCK_I,
  // watched outputs
  input wire       RIGHT_ZERO_FLAG_PIN_O,
  input wire [7:0] LEFT_GAIN_O,
  input wire [7:0] RIGHT_GAIN_O,
  input wire [2:0] INPUT_FORMAT_O,
  input wire [1:0] EMPHASIS_RATE_O,
  input wire       EMPHASIS_ENABLE_O,
  input wire       OUTPUT_PHASE_INVERT_O,
  input wire       ONE_BIT_STREAM_MODE_O,
  input wire       STREAM_BIT_VALID_O
);
  // ---------------------------------------------------------------
  // helper counters, saturating so long runs never wrap
  // ---------------------------------------------------------------
  reg [15:0] low_cnt_ff;
  reg [15:0] mode_cnt_ff;

  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      low_cnt_ff  <= 16'h0000;
      mode_cnt_ff <= 16'h0000;
    end
    else
    begin
      low_cnt_ff  <= PCM_DATA_I ? 16'h0000 :
                     low_cnt_ff + {15'h0000, ~&low_cnt_ff};
      mode_cnt_ff <= !ONE_BIT_STREAM_MODE_O ? 16'h0000 :
                     mode_cnt_ff + {15'h0000, ~&mode_cnt_ff};
    end
  end

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  reset_vals_a: assert property ($rose(RST_N_I) |->
    LEFT_GAIN_O == 8'hff && RIGHT_GAIN_O == 8'hff &&
    INPUT_FORMAT_O == 3'h5 && EMPHASIS_RATE_O == 2'h0 &&
    !EMPHASIS_ENABLE_O && !ONE_BIT_STREAM_MODE_O)
    else $error("settings wrong after reset");
  cfg_hold_idle_a: assert property (CONTROL_SELECT_N_I [*8] |=>
    $stable({INPUT_FORMAT_O, EMPHASIS_RATE_O, EMPHASIS_ENABLE_O,
             OUTPUT_PHASE_INVERT_O, ONE_BIT_STREAM_MODE_O}))
    else $error("setting changed with select idle");
  gain_ramp_a: assert property (
    CONTROL_SELECT_N_I [*8] ##1 (LEFT_GAIN_O != $past(LEFT_GAIN_O)) |->
    LEFT_GAIN_O == $past(LEFT_GAIN_O) - 8'h01 ||
    LEFT_GAIN_O == $past(LEFT_GAIN_O) + 8'h01)
    else $error("gain jumped with select idle");
  stream_pulse_a: assert property (STREAM_BIT_VALID_O |=>
    !STREAM_BIT_VALID_O)
    else $error("stream valid longer than one cycle");
  stream_follow_a: assert property ($rose(STREAM_BIT_CLOCK_I) |->
    ##[1:8] STREAM_BIT_VALID_O)
    else $error("stream edge not sampled");
  stream_mode_a: assert property (STREAM_BIT_VALID_O |->
    ONE_BIT_STREAM_MODE_O)
    else $error("stream bit taken outside stream mode");
  pcm_zero_a: assert property (
    $rose(RIGHT_ZERO_FLAG_PIN_O) && !ONE_BIT_STREAM_MODE_O |->
    low_cnt_ff >= ZERO_WORDS * 16)
    else $error("pcm zero flag too early");
  stream_zero_a: assert property (
    $rose(RIGHT_ZERO_FLAG_PIN_O) && ONE_BIT_STREAM_MODE_O |->
    mode_cnt_ff >= STREAM_CYC)
    else $error("stream zero flag too early");

  flag_rise_c: cover property ($rose(RIGHT_ZERO_FLAG_PIN_O));
  gain_move_c: cover property ($changed(LEFT_GAIN_O));
  stream_bit_c: cover property (STREAM_BIT_VALID_O);
endmodule // adczd_chk

bind adczd_top adczd_chk #(
  .ZERO_WORDS (ZERO_WORDS),
  .STREAM_CYC (STREAM_CYC)
) u_chk (
  .SYS_CLK_I             (SYS_CLK_I),
  .RST_N_I               (RST_N_I),
  .CONTROL_SELECT_N_I    (CONTROL_SELECT_N_I),
  .PCM_DATA_I            (PCM_DATA_I),
  .STREAM_BIT_CLOCK_I    (STREAM_BIT_CLOCK_I),
  .RIGHT_ZERO_FLAG_PIN_O (RIGHT_ZERO_FLAG_PIN_O),
  .LEFT_GAIN_O           (LEFT_GAIN_O),
  .RIGHT_GAIN_O          (RIGHT_GAIN_O),
  .INPUT_FORMAT_O        (INPUT_FORMAT_O),
  .EMPHASIS_RATE_O       (EMPHASIS_RATE_O),
  .EMPHASIS_ENABLE_O     (EMPHASIS_ENABLE_O),
  .OUTPUT_PHASE_INVERT_O (OUTPUT_PHASE_INVERT_O),
  .ONE_BIT_STREAM_MODE_O (ONE_BIT_STREAM_MODE_O),
  .STREAM_BIT_VALID_O    (STREAM_BIT_VALID_O)
);

// File: adczd_top_test.sv
// adczd_top_test.sv: self-checking bench for adczd_top.
// assumes adczd_host drives the control port; counts are shortened
// through the top's parameters.
`timescale 1ns/1ps

module adczd_top_test;
  reg        sys_clk;
  reg        rst_n;
  reg        wclk, bclk, pdat, sbck, sl, sr;
  wire       sdi, sck, sel_n, zl, zr, sv, slb, srb, phase, smode, emen;
  wire [7:0] gl, gr;
  wire [2:0] fmt;
  wire [1:0] rate;
  reg  [7:0] rd;
  integer    mismatches, total_checks, i;
  reg  [6:0] idx [0:5];
  reg  [7:0] val [0:5];

  adczd_top #(.ZERO_WORDS(4), .STREAM_CYC(200), .RAMP_DIV(3)) dut (
    .SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
    .CONTROL_SERIAL_IN_I(sdi), .CONTROL_BIT_CLOCK_I(sck),
    .CONTROL_SELECT_N_I(sel_n), .PCM_WORD_CLOCK_I(wclk),
    .PCM_BIT_CLOCK_I(bclk), .PCM_DATA_I(pdat),
    .STREAM_BIT_CLOCK_I(sbck), .STREAM_LEFT_DATA_I(sl),
    .STREAM_RIGHT_DATA_I(sr), .LEFT_ZERO_FLAG_PIN_O(zl),
    .RIGHT_ZERO_FLAG_PIN_O(zr), .LEFT_GAIN_O(gl), .RIGHT_GAIN_O(gr),
    .INPUT_FORMAT_O(fmt), .EMPHASIS_RATE_O(rate),
    .EMPHASIS_ENABLE_O(emen), .OUTPUT_PHASE_INVERT_O(phase),
    .ONE_BIT_STREAM_MODE_O(smode), .STREAM_LEFT_BIT_O(slb),
    .STREAM_RIGHT_BIT_O(srb), .STREAM_BIT_VALID_O(sv));

  adczd_host host (.clk_i(sys_clk), .rdbk_i(zl),
    .control_serial_in_o(sdi), .control_bit_clock_o(sck),
    .control_select_n_o(sel_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task results;
  begin
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  task check(input string nm, input [7:0] seen, input [7:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask

  task wait_c(input integer n);
  begin
    repeat (n) @(posedge sys_clk);
    #1;
  end
  endtask

  task wr(input [6:0] a, input [7:0] d);
    reg [7:0] junk;
  begin
    host.xfer({1'b0, a, d}, 16, junk);
  end
  endtask

  task rdr(input [6:0] a, output [7:0] d);
  begin
    host.xfer({1'b1, a, 8'h00}, 16, d);
  end
  endtask

  // eight bit clocks per word, word clock low for the first half
  task pcm(input integer n);
    integer w, b;
  begin
    for (w = 0; w < n; w = w + 1)
      for (b = 0; b < 8; b = b + 1)
      begin
        wclk = (b >= 4);
        bclk = 1'b0;
        wait_c(5);
        bclk = 1'b1;
        wait_c(5);
      end
    wclk = 1'b0;
    bclk = 1'b0;
  end
  endtask

  // stream clock of 64 ns, standing low outside the burst
  task strm(input [7:0] l, input [7:0] r, input integer n);
    integer g, b;
  begin
    for (g = 0; g < n; g = g + 1)
      for (b = 7; b >= 0; b = b - 1)
      begin
        sl = l[b];
        sr = r[b];
        sbck = 1'b0;
        wait_c(4);
        sbck = 1'b1;
        wait_c(4);
      end
    sbck = 1'b0;
  end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
  begin
    wr(7'h13, 8'h08);
    for (i = 0; i < 6; i = i + 1)
    begin
      rdr(idx[i], rd);
      check("readback", rd, val[i]);
    end
    check("gain l", gl, 8'hff);
    check("format", {5'h00, fmt}, 8'h05);
    check("emph en", {7'h00, emen}, 8'h00);
    $display("t_regs done");
  end
  endtask

  task t_write;
  begin
    wr(7'h10, 8'h3c);
    check("gain l", gl, 8'h3c);
    host.xfer({1'b0, 7'h11, 8'h81}, 12, rd);
    check("gain r cut", gr, 8'hff);
    wr(7'h11, 8'h81);
    check("gain r", gr, 8'h81);
    wr(7'h12, 8'h2e);
    check("format", {5'h00, fmt}, 8'h02);
    check("rate", {6'h00, rate}, 8'h03);
    check("emph en", {7'h00, emen}, 8'h01);
    wr(7'h13, 8'h88);
    check("phase", {7'h00, phase}, 8'h01);
    rdr(7'h10, rd);
    check("read l", rd, 8'h3c);
    $display("t_write done");
  end
  endtask

  task t_mute;
  begin
    wr(7'h12, 8'h2f);
    wait_c(30);
    check("ramp mid", {7'h00, gl < 8'h3c && gl != 8'h00}, 8'h01);
    wait_c(400);
    check("ramp end", gl, 8'h00);
    wr(7'h12, 8'h2e);
    $display("t_mute done");
  end
  endtask

  task t_pcm;
  begin
    pcm(2);
    check("zero r early", {7'h00, zr}, 8'h00);
    pcm(4);
    check("zero and", {7'h00, zr}, 8'h01);
    rdr(7'h16, rd);
    check("zero stat", rd, 8'h03);
    wr(7'h13, 8'h00);
    check("zero l", {7'h00, zl}, 8'h01);
    check("zero r", {7'h00, zr}, 8'h01);
    pdat = 1'b1;
    pcm(1);
    pdat = 1'b0;
    wait_c(10);
    check("zero l data", {7'h00, zl}, 8'h00);
    wr(7'h14, 8'h10);
    pcm(5);
    check("zero bypass", {7'h00, zr}, 8'h01);
    $display("t_pcm done");
  end
  endtask

  task t_stream;
  begin
    wr(7'h15, 8'h02);
    wr(7'h14, 8'h20);
    check("stream mode", {7'h00, smode}, 8'h01);
    strm(8'hff, 8'h00, 2);
    wait_c(10);
    check("bit l", {7'h00, slb}, 8'h01);
    check("bit r", {7'h00, srb}, 8'h00);
    strm(8'hff, 8'hff, 4);
    check("unbalanced", {7'h00, zr}, 8'h00);
    strm(8'h96, 8'h96, 8);
    check("balanced", {7'h00, zr}, 8'h01);
    wr(7'h15, 8'h04);
    strm(8'h5a, 8'h5a, 2);
    check("no pattern", {7'h00, zr}, 8'h00);
    strm(8'h96, 8'h96, 8);
    check("pattern", {7'h00, zr}, 8'h01);
    $display("t_stream done");
  end
  endtask

  initial
  begin
    #400000;
    mismatches = mismatches + 1;
    results;
  end

  initial
  begin
    {rst_n, wclk, bclk, pdat, sbck, sl, sr} = 7'h00;
    mismatches = 0;
    total_checks = 0;
    idx[0] = 7'h13; val[0] = 8'h08;
    idx[1] = 7'h10; val[1] = 8'hff;
    idx[2] = 7'h12; val[2] = 8'h50;
    idx[3] = 7'h14; val[3] = 8'h00;
    idx[4] = 7'h15; val[4] = 8'h01;
    idx[5] = 7'h20; val[5] = 8'h00;
    wait_c(20);
    rst_n = 1'b1;
    wait_c(10);
    t_regs;
    t_write;
    t_mute;
    t_pcm;
    t_stream;
    results;
  end
endmodule // adczd_top_test
